//--- rtl/dma_ep_engine.sv
// endpoint end: header registers, descriptor fetch and the two requesters
// assumes the host answers every read with one completion word
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - table is header then four-word descriptors
// - host loads header before engine runs it
// - first word: count low, control high
// - table base upper and lower words
// - bit 16 picks write or read direction
// - bit 17 enables interrupts for whole table
// - bit 18 enables completion reports for table
// - bits 24..20 drive interrupt vector output
// - bits 30..28 drive interrupt traffic class
// - ready count register set by host
// - word 0 length, control, reserved bits
// - word 1 is endpoint memory address
// - words 2,3 host address upper, lower
// - descriptor report bit ORed with header's
// - descriptor interrupt bit ORed with header's
// - accept header writes on bar 2 or 3
// - fetch descriptors by memory reads
// - requesters move data by reads or writes
module dma_ep_engine
  import dma_pkg::*;
#(
  parameter int EP_WORDS = 1024
) (
  input  wire logic                        I_CORE_CLK,
  input  wire logic                        I_SRST,
  dma_link_if.ep                           LINK,
  input  wire logic                        I_MEM_WE,
  input  wire logic [$clog2(EP_WORDS)-1:0] I_MEM_ADDR,
  input  wire logic [31:0]                 I_MEM_WDATA,
  output logic      [31:0]                 O_MEM_RDATA,
  output logic                             O_BUSY,
  output logic      [4:0]                  O_MSI_NUM,
  output logic      [2:0]                  O_MSI_TC
);
  localparam int AW = $clog2(EP_WORDS);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] hdr_q [2][4];
  logic [15:0] idx_q [2];
  logic [31:0] desc_q [DESC_WORDS];
  logic [31:0] mem [EP_WORDS];
  state_t      st_q;
  logic        ch_q;
  logic [1:0]  wd_q;
  logic [15:0] cnt_q;
  logic        wait_q;
  logic        rq_valid_q;
  logic        rq_write_q;
  logic [63:0] rq_addr_q;
  logic [31:0] rq_data_q;
  logic        msi_valid_q;

  function automatic logic pending(input logic [31:0] ctrl, input logic [31:0] rdy,
                                   input logic [15:0] idx);
    pending = (idx < ctrl[15:0]) && (idx < rdy[15:0]);
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire         bar_ok   = (LINK.hw_bar == BAR_CTRL_A) || (LINK.hw_bar == BAR_CTRL_B);
  wire         hw_hit   = LINK.hw_valid && bar_ok && (LINK.hw_addr < CTRL_WIN_END);
  wire         hw_ch    = LINK.hw_addr[4];
  wire [1:0]   hw_wd    = LINK.hw_addr[3:2];
  wire         pend0    = pending(hdr_q[0][0], hdr_q[0][3], idx_q[0]);
  wire         pend1    = pending(hdr_q[1][0], hdr_q[1][3], idx_q[1]);
  wire [31:0]  ctrl     = hdr_q[ch_q][0];
  wire [63:0]  tbase    = {hdr_q[ch_q][1], hdr_q[ch_q][2]};
  wire         dir_wr   = ctrl[F_DIR];
  wire [15:0]  nwords   = 16'((17'(desc_q[0][15:0]) + 17'h3) >> 2);
  wire         mail_en  = ctrl[F_MAIL] | desc_q[0][D_MAIL];
  wire         msi_en   = ctrl[F_MSI] | desc_q[0][D_MSI];
  wire [AW-1:0] ep_word = AW'(desc_q[1][31:2] + 30'(cnt_q));
  wire [63:0]  host_xfr = {desc_q[2], desc_q[3]} + 64'({cnt_q, 2'b00});
  wire [63:0]  desc_adr = tbase + HDR_BYTES + 64'({idx_q[ch_q], 4'h0})
                          + 64'({wd_q, 2'b00});
  wire [63:0]  mail_adr = tbase + MAILBOX_OFS;
  wire         slot     = !rq_valid_q && !wait_q;
  wire         rq_done  = rq_valid_q && LINK.rq_ready;
  wire         cp_take  = wait_q && LINK.cp_valid;
  wire         xfr_end  = (st_q == S_XFER) && slot && (cnt_q >= nwords);
  wire         finish   = (xfr_end && !mail_en && !msi_en)
                          || ((st_q == S_MAIL) && rq_done && !msi_en)
                          || (st_q == S_MSI);
  wire         eng_we   = (st_q == S_XFER) && cp_take;

  // ---------------------------------------------------------------
  // header registers, written only from the host side
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      hdr_q <= '{default: HDR_RESET};
    end else if (hw_hit) begin
      hdr_q[hw_ch][hw_wd] <= LINK.hw_data;
    end
  end

  // a fresh control word restarts that table from descriptor zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      idx_q <= '{default: 16'h0000};
    end else if (hw_hit && (hw_wd == 2'h0)) begin
      idx_q[hw_ch] <= 16'h0000;
    end else if (finish) begin
      idx_q[ch_q] <= idx_q[ch_q] + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // endpoint memory, engine write wins over user write
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (eng_we) begin
      mem[ep_word] <= LINK.cp_data;
    end else if (I_MEM_WE) begin
      mem[I_MEM_ADDR] <= I_MEM_WDATA;
    end
    O_MEM_RDATA <= mem[I_MEM_ADDR];
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_q        <= S_IDLE;
      ch_q        <= 1'b0;
      wd_q        <= 2'h0;
      cnt_q       <= 16'h0000;
      wait_q      <= 1'b0;
      rq_valid_q  <= 1'b0;
      rq_write_q  <= 1'b0;
      rq_addr_q   <= 64'h0;
      rq_data_q   <= 32'h0;
      msi_valid_q <= 1'b0;
      O_BUSY      <= 1'b0;
      O_MSI_NUM   <= 5'h00;
      O_MSI_TC    <= 3'h0;
      desc_q      <= '{default: 32'h0};
    end else begin
      msi_valid_q <= 1'b0;
      if (rq_done) begin
        rq_valid_q <= 1'b0;
        wait_q     <= !rq_write_q;
      end
      case (st_q)
        S_IDLE: begin
          O_BUSY <= pend0 | pend1;
          if (pend0 | pend1) begin
            ch_q <= !pend0;
            wd_q <= 2'h0;
            st_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (slot) begin
            rq_valid_q <= 1'b1;
            rq_write_q <= 1'b0;
            rq_addr_q  <= desc_adr;
          end
          if (cp_take) begin
            desc_q[wd_q] <= LINK.cp_data;
            wait_q       <= 1'b0;
            wd_q         <= wd_q + 2'h1;
            if (wd_q == 2'h3) begin
              cnt_q <= 16'h0000;
              st_q  <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (xfr_end) begin
            st_q <= mail_en ? S_MAIL : (msi_en ? S_MSI : S_IDLE);
          end else if (slot) begin
            rq_valid_q <= 1'b1;
            rq_write_q <= dir_wr;
            rq_addr_q  <= host_xfr;
            rq_data_q  <= mem[ep_word];
          end
          if ((rq_done && rq_write_q) || cp_take) begin
            cnt_q <= cnt_q + 16'h0001;
          end
          if (cp_take) begin
            wait_q <= 1'b0;
          end
        end
        S_MAIL: begin
          if (slot) begin
            rq_valid_q <= 1'b1;
            rq_write_q <= 1'b1;
            rq_addr_q  <= mail_adr;
            rq_data_q  <= {16'h0000, idx_q[ch_q]};
          end
          if (rq_done) begin
            st_q <= msi_en ? S_MSI : S_IDLE;
          end
        end
        S_MSI: begin
          msi_valid_q <= 1'b1;
          O_MSI_NUM   <= ctrl[F_NUM_LO +: 5];
          O_MSI_TC    <= ctrl[F_TC_LO +: 3];
          st_q        <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // link drive
  // ---------------------------------------------------------------
  assign LINK.rq_valid  = rq_valid_q;
  assign LINK.rq_write  = rq_write_q;
  assign LINK.rq_addr   = rq_addr_q;
  assign LINK.rq_data   = rq_data_q;
  assign LINK.msi_valid = msi_valid_q;
  assign LINK.msi_num   = O_MSI_NUM;
  assign LINK.msi_tc    = O_MSI_TC;
endmodule

//--- rtl/dma_link_if.sv
// link between the endpoint dma engine and the root complex end
// assumes both ends run on one clock; the bench joins them
`timescale 1ns/100ps
interface dma_link_if;
  logic        hw_valid;
  logic [2:0]  hw_bar;
  logic [7:0]  hw_addr;
  logic [31:0] hw_data;
  logic        rq_valid;
  logic        rq_ready;
  logic        rq_write;
  logic [63:0] rq_addr;
  logic [31:0] rq_data;
  logic        cp_valid;
  logic [31:0] cp_data;
  logic        msi_valid;
  logic [4:0]  msi_num;
  logic [2:0]  msi_tc;

  modport ep (input hw_valid, hw_bar, hw_addr, hw_data, rq_ready, cp_valid, cp_data,
              output rq_valid, rq_write, rq_addr, rq_data, msi_valid, msi_num, msi_tc);
  modport rc (output hw_valid, hw_bar, hw_addr, hw_data, rq_ready, cp_valid, cp_data,
              input rq_valid, rq_write, rq_addr, rq_data, msi_valid, msi_num, msi_tc);
endinterface

//--- rtl/dma_pkg.sv
// shared constants and types of the chaining dma engine and its host end
// assumes byte addressing on the link and 32-bit words everywhere
package dma_pkg;
  // ---------------------------------------------------------------
  // header register map, offsets in the control window
  // ---------------------------------------------------------------
  localparam logic [7:0] WR_CHAN_BASE = 8'h00;
  localparam logic [7:0] RD_CHAN_BASE = 8'h10;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_BASE_HI  = 8'h04;
  localparam logic [7:0] OFS_BASE_LO  = 8'h08;
  localparam logic [7:0] OFS_READY    = 8'h0C;
  localparam logic [7:0] CTRL_WIN_END = 8'h20;
  localparam logic [2:0] BAR_CTRL_A   = 3'h2;
  localparam logic [2:0] BAR_CTRL_B   = 3'h3;
  localparam logic [31:0] HDR_RESET   = 32'h0000_0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int F_DIR    = 16;
  localparam int F_MSI    = 17;
  localparam int F_MAIL   = 18;
  localparam int F_NUM_LO = 20;
  localparam int F_TC_LO  = 28;
  localparam int D_MAIL   = 16;
  localparam int D_MSI    = 17;
  // ---------------------------------------------------------------
  // host memory layout of a table
  // ---------------------------------------------------------------
  localparam logic [63:0] HDR_BYTES   = 64'h10;
  localparam logic [63:0] MAILBOX_OFS = 64'h0C;
  localparam int DESC_WORDS = 4;
  // ---------------------------------------------------------------
  // host end register map
  // ---------------------------------------------------------------
  localparam logic [7:0] H_CMD_ADDR = 8'h00;
  localparam logic [7:0] H_CMD_DATA = 8'h04;
  localparam logic [7:0] H_CMD_CTRL = 8'h08;
  localparam logic [7:0] H_RDATA    = 8'h0C;
  localparam logic [7:0] H_STATUS   = 8'h10;
  localparam logic [7:0] H_MASK     = 8'h14;
  localparam logic [7:0] H_MSI_INFO = 8'h18;
  localparam logic [7:0] H_WATCH    = 8'h1C;
  localparam int C_HDR_WR = 0;
  localparam int C_MEM_WR = 1;
  localparam int C_MEM_RD = 2;
  localparam int C_BAR_LO = 4;
  localparam int EV_MSI   = 0;
  localparam int EV_MAIL  = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_XFER, S_MAIL, S_MSI} state_t;
endpackage

//--- rtl/dma_rc_host.sv
// root complex end: host memory, header writes, interrupt capture
// assumes an axi4-lite master with one write and one read outstanding
`timescale 1ns/100ps
module dma_rc_host
  import dma_pkg::*;
#(
  parameter int HOST_WORDS = 1024
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_SRST,
  dma_link_if.rc           LINK,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic      [1:0]  O_BRESP,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic      [31:0] O_RDATA,
  output logic      [1:0]  O_RRESP,
  output logic             O_IRQ
);
  localparam int HW = $clog2(HOST_WORDS);

  logic [31:0] hmem [HOST_WORDS];
  logic [31:0] cmd_addr_q, cmd_data_q, rdata_q, watch_q, msi_info_q;
  logic [1:0]  stat_q, mask_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        hw_valid_q, rq_ready_q, cp_valid_q;
  logic [2:0]  hw_bar_q;
  logic [31:0] cp_data_q;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire        do_wr   = aw_q && w_q && !O_BVALID;
  wire        wr_ok   = (awaddr_q <= H_WATCH) && (awaddr_q[1:0] == 2'h0);
  wire        wr_ctrl = do_wr && (awaddr_q == H_CMD_CTRL);
  wire        sw_mwr  = wr_ctrl && wdata_q[C_MEM_WR];
  wire        sw_mrd  = wr_ctrl && wdata_q[C_MEM_RD];
  wire        dev_rq  = LINK.rq_valid && rq_ready_q;
  wire        dev_wr  = dev_rq && LINK.rq_write;
  wire [HW-1:0] dev_w = LINK.rq_addr[HW+1:2];
  wire [HW-1:0] sw_w  = cmd_addr_q[HW+1:2];
  wire [1:0]  ev      = {dev_wr && (LINK.rq_addr[31:0] == watch_q), LINK.msi_valid};
  wire [1:0]  clr     = (do_wr && (awaddr_q == H_STATUS)) ? wdata_q[1:0] : 2'h0;
  wire        rd_ok   = (I_ARADDR <= H_WATCH) && (I_ARADDR[1:0] == 2'h0);
  wire [31:0] rd_mux  = (I_ARADDR == H_CMD_ADDR) ? cmd_addr_q :
                        (I_ARADDR == H_CMD_DATA) ? cmd_data_q :
                        (I_ARADDR == H_RDATA)    ? rdata_q :
                        (I_ARADDR == H_STATUS)   ? {30'h0, stat_q} :
                        (I_ARADDR == H_MASK)     ? {30'h0, mask_q} :
                        (I_ARADDR == H_MSI_INFO) ? msi_info_q :
                        (I_ARADDR == H_WATCH)    ? watch_q : 32'h0;

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      O_AWREADY <= I_AWVALID && !aw_q && !O_AWREADY;
      O_WREADY  <= I_WVALID && !w_q && !O_WREADY;
      if (I_AWVALID && O_AWREADY) begin
        aw_q     <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_q     <= 1'b1;
        wdata_q <= I_WDATA;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      cmd_addr_q <= 32'h0;
      cmd_data_q <= 32'h0;
      watch_q    <= 32'h0;
      mask_q     <= 2'h0;
      stat_q     <= 2'h0;
      msi_info_q <= 32'h0;
      rdata_q    <= 32'h0;
      O_IRQ      <= 1'b0;
      hw_valid_q <= 1'b0;
      hw_bar_q   <= 3'h0;
    end else begin
      if (do_wr && awaddr_q == H_CMD_ADDR) cmd_addr_q <= wdata_q;
      if (do_wr && awaddr_q == H_CMD_DATA) cmd_data_q <= wdata_q;
      if (do_wr && awaddr_q == H_MASK) mask_q <= wdata_q[1:0];
      if (do_wr && awaddr_q == H_WATCH) watch_q <= wdata_q;
      stat_q <= (stat_q & ~clr) | ev;
      O_IRQ  <= |(((stat_q & ~clr) | ev) & mask_q);
      if (LINK.msi_valid) msi_info_q <= {24'h0, LINK.msi_tc, LINK.msi_num};
      if (sw_mrd) rdata_q <= hmem[sw_w];
      hw_valid_q <= wr_ctrl && wdata_q[C_HDR_WR];
      if (wr_ctrl) hw_bar_q <= wdata_q[C_BAR_LO +: 3];
    end
  end

  // ---------------------------------------------------------------
  // host memory and device requests
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (dev_wr) begin
      hmem[dev_w] <= LINK.rq_data;
    end else if (sw_mwr) begin
      hmem[sw_w] <= cmd_data_q;
    end
    cp_data_q <= hmem[dev_w];
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      rq_ready_q <= 1'b0;
      cp_valid_q <= 1'b0;
      O_ARREADY  <= 1'b0;
      O_RVALID   <= 1'b0;
      O_RDATA    <= 32'h0;
      O_RRESP    <= RESP_OKAY;
    end else begin
      rq_ready_q <= 1'b1;
      cp_valid_q <= dev_rq && !LINK.rq_write;
      O_ARREADY  <= I_ARVALID && !O_ARREADY && !O_RVALID;
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA  <= rd_mux;
        O_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  assign LINK.hw_valid = hw_valid_q;
  assign LINK.hw_bar   = hw_bar_q;
  assign LINK.hw_addr  = cmd_addr_q[7:0];
  assign LINK.hw_data  = cmd_data_q;
  assign LINK.rq_ready = rq_ready_q;
  assign LINK.cp_valid = cp_valid_q;
  assign LINK.cp_data  = cp_data_q;
endmodule

//--- tb/dma_link_properties.sv
// link checker for the dma engine and its host end
// assumes it is instantiated beside the link interface in the bench
`timescale 1ns/100ps
module dma_link_properties
  import dma_pkg::*;
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_SRST,
  input wire logic        hw_valid,
  input wire logic [2:0]  hw_bar,
  input wire logic [7:0]  hw_addr,
  input wire logic        rq_valid,
  input wire logic        rq_ready,
  input wire logic        rq_write,
  input wire logic [63:0] rq_addr,
  input wire logic [31:0] rq_data,
  input wire logic        cp_valid,
  input wire logic        msi_valid
);
  // ---------------------------------------------------------------
  // link properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  property p_msi_pulse; msi_valid |=> !msi_valid; endproperty
  a_msi_pulse: assert property (p_msi_pulse)
    else $error("interrupt message longer than one cycle");
  property p_rq_hold;
    rq_valid && !rq_ready |=> rq_valid && $stable(rq_addr) && $stable(rq_write)
      && (!rq_write || $stable(rq_data));
  endproperty
  a_rq_hold: assert property (p_rq_hold)
    else $error("request changed before taken");
  property p_cp_after_rd; rq_valid && rq_ready && !rq_write |=> cp_valid; endproperty
  a_cp_after_rd: assert property (p_cp_after_rd)
    else $error("read not completed one cycle later");
  property p_cp_cause; cp_valid |-> $past(rq_valid && rq_ready && !rq_write); endproperty
  a_cp_cause: assert property (p_cp_cause)
    else $error("completion without a read");
  property p_one_out; rq_valid && rq_ready && !rq_write |=> !rq_valid; endproperty
  a_one_out: assert property (p_one_out)
    else $error("request issued while a read is outstanding");
  property p_aligned; rq_valid |-> rq_addr[1:0] == 2'h0; endproperty
  a_aligned: assert property (p_aligned)
    else $error("request address not word aligned");
  property p_hw_pulse; hw_valid |=> !hw_valid; endproperty
  a_hw_pulse: assert property (p_hw_pulse)
    else $error("header write longer than one cycle");
  property p_hw_bar; hw_valid |-> hw_bar == BAR_CTRL_A || hw_bar == BAR_CTRL_B; endproperty
  a_hw_bar: assert property (p_hw_bar)
    else $error("header write on wrong bar");
  property p_hw_win; hw_valid |-> hw_addr < CTRL_WIN_END; endproperty
  a_hw_win: assert property (p_hw_win)
    else $error("header write outside control window");
endmodule

//--- tb/tb_top.sv
// bench joining the dma engine to its host end over the link
// assumes software reaches the host end over axi4-lite only
`timescale 1ns/100ps
module tb_top
  import dma_pkg::*;
;
  logic        core_clk, srst, awvalid, wvalid, bready, arvalid, rready, mem_we;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, mem_wdata, d;
  logic [5:0]  mem_addr;
  logic [1:0]  r;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, busy;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, mem_rdata;
  wire logic [4:0]  msi_num;
  wire logic [2:0]  msi_tc;
  int errors, checks;
  dma_link_if i_dma_link_if ();
  dma_ep_engine #(.EP_WORDS(64)) i_dma_ep_engine (.I_CORE_CLK(core_clk), .I_SRST(srst),
    .LINK(i_dma_link_if), .I_MEM_WE(mem_we), .I_MEM_ADDR(mem_addr), .I_MEM_WDATA(mem_wdata),
    .O_MEM_RDATA(mem_rdata), .O_BUSY(busy), .O_MSI_NUM(msi_num), .O_MSI_TC(msi_tc));
  dma_rc_host i_dma_rc_host (.I_CORE_CLK(core_clk), .I_SRST(srst), .LINK(i_dma_link_if),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
    .O_WREADY(wready), .I_WDATA(wdata), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .O_IRQ(irq));
  dma_link_properties i_dma_link_properties (.I_CORE_CLK(core_clk), .I_SRST(srst),
    .hw_valid(i_dma_link_if.hw_valid), .hw_bar(i_dma_link_if.hw_bar),
    .hw_addr(i_dma_link_if.hw_addr), .rq_valid(i_dma_link_if.rq_valid),
    .rq_ready(i_dma_link_if.rq_ready), .rq_write(i_dma_link_if.rq_write),
    .rq_addr(i_dma_link_if.rq_addr), .rq_data(i_dma_link_if.rq_data),
    .cp_valid(i_dma_link_if.cp_valid), .msi_valid(i_dma_link_if.msi_valid));
  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tmo;
    chk(32'h1, 32'h0);
    results;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      if (bvalid) break;
    end
    if (n == 100) tmo;
    rs = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      arvalid <= arvalid & ~arready;
      if (rvalid) break;
    end
    if (n == 100) tmo;
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axw(a, v, rs);
    chk(32'(RESP_OKAY), 32'(rs));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] rs;
    axr(a, v, rs);
    chk(32'(RESP_OKAY), 32'(rs));
  endtask
  task automatic hmem_wr(input logic [31:0] a, input logic [31:0] v);
    wr(H_CMD_ADDR, a);
    wr(H_CMD_DATA, v);
    wr(H_CMD_CTRL, 32'h2);
  endtask
  task automatic hmem_rd(input logic [31:0] a, output logic [31:0] v);
    wr(H_CMD_ADDR, a);
    wr(H_CMD_CTRL, 32'h4);
    rd(H_RDATA, v);
  endtask
  task automatic hdr(input logic [7:0] o, input logic [31:0] v, input logic [2:0] bar);
    wr(H_CMD_ADDR, {24'h0, o});
    wr(H_CMD_DATA, v);
    wr(H_CMD_CTRL, {25'h0, bar, 4'h1});
  endtask
  task automatic desc(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] w1,
                      input logic [31:0] w3);
    hmem_wr(a, w0);
    hmem_wr(a + 32'h4, w1);
    hmem_wr(a + 32'h8, 32'h0);
    hmem_wr(a + 32'hC, w3);
  endtask
  task automatic wait_st(input int k);
    int n;
    logic [31:0] s;
    for (n = 0; n < 300; n++) begin
      rd(H_STATUS, s);
      if (s[k]) break;
    end
    if (n == 300) tmo;
  endtask
  task automatic ep_rd(input logic [5:0] a, output logic [31:0] v);
    mem_addr <= a;
    repeat (2) @(posedge core_clk);
    v = mem_rdata;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    wr(H_MASK, 32'h3);
    rd(H_MASK, d);
    chk(32'h3, d);
    axw(8'h20, 32'h1, r);
    chk(32'(RESP_SLVERR), 32'(r));
    axw(8'h15, 32'h1, r);
    chk(32'(RESP_SLVERR), 32'(r));
    axr(8'h24, d, r);
    chk(32'(RESP_SLVERR), 32'(r));
    chk(32'h0, d);
    $display("test regs done");
  endtask
  task automatic t_write_dir;
    mem_we <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      mem_addr <= 6'(k);
      mem_wdata <= 32'hA5A5_0000 + k;
      @(posedge core_clk);
    end
    mem_we <= 1'b0;
    desc(32'h110, 32'h0000_0008, 32'h0, 32'h200);
    wr(H_WATCH, 32'h10C);
    hdr(WR_CHAN_BASE | OFS_BASE_HI, 32'h0, 3'h2);
    hdr(WR_CHAN_BASE | OFS_BASE_LO, 32'h100, 3'h2);
    hdr(WR_CHAN_BASE | OFS_CTRL, 32'h5037_0001, 3'h2);
    hdr(WR_CHAN_BASE | OFS_READY, 32'h1, 3'h3);
    @(posedge core_clk);
    chk(32'h1, {31'h0, busy});
    wait_st(EV_MSI);
    rd(H_STATUS, d);
    chk(32'h3, d);
    chk(32'h1, {31'h0, irq});
    hmem_rd(32'h10C, d);
    chk(32'h0, d);
    hmem_rd(32'h200, d);
    chk(32'hA5A5_0000, d);
    hmem_rd(32'h204, d);
    chk(32'hA5A5_0001, d);
    rd(H_MSI_INFO, d);
    chk(32'hA3, d);
    chk(32'h3, {27'h0, msi_num});
    chk(32'h5, {29'h0, msi_tc});
    wr(H_STATUS, 32'h3);
    chk(32'h0, {31'h0, irq});
    $display("test write direction done");
  endtask
  task automatic t_read_gate;
    hmem_wr(32'h400, 32'hC3C3_0001);
    hmem_wr(32'h404, 32'hC3C3_0002);
    desc(32'h310, 32'h0001_0004, 32'h20, 32'h400);
    desc(32'h320, 32'h0003_0004, 32'h24, 32'h404);
    wr(H_WATCH, 32'h30C);
    wr(H_MASK, 32'h0);
    hdr(RD_CHAN_BASE | OFS_BASE_HI, 32'h0, 3'h3);
    hdr(RD_CHAN_BASE | OFS_BASE_LO, 32'h300, 3'h3);
    hdr(RD_CHAN_BASE | OFS_CTRL, 32'h0000_0002, 3'h3);
    hdr(RD_CHAN_BASE | OFS_READY, 32'h1, 3'h3);
    wait_st(EV_MAIL);
    chk(32'h0, {31'h0, irq});
    chk(32'h0, {31'h0, busy});
    wr(H_MASK, 32'h3);
    chk(32'h1, {31'h0, irq});
    hmem_rd(32'h30C, d);
    chk(32'h0, d);
    ep_rd(6'h8, d);
    chk(32'hC3C3_0001, d);
    rd(H_STATUS, d);
    chk(32'h2, d);
    wr(H_STATUS, 32'h3);
    hdr(RD_CHAN_BASE | OFS_READY, 32'h2, 3'h2);
    wait_st(EV_MSI);
    hmem_rd(32'h30C, d);
    chk(32'h1, d);
    ep_rd(6'h9, d);
    chk(32'hC3C3_0002, d);
    chk(32'h0, {27'h0, msi_num});
    wr(H_STATUS, 32'h3);
    $display("test read direction done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready, mem_we} = 7'h40;
    {awaddr, araddr, wdata, mem_wdata, mem_addr} = '0;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_write_dir;
    t_read_gate;
    results;
  end
endmodule
